// *** rtl/fsad_pkg.sv ***
// Shared codes and widths for the four-bit slice datapath.
package fsad_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 4;
	localparam int ADDR_W = 4;
	localparam int WORDS = 16;
	localparam int CODE_W = 3;

	// ----------------------------------------
	// Microinstruction fields
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRC_AQ = 3'b000,
		SRC_AB = 3'b001,
		SRC_ZQ = 3'b010,
		SRC_ZB = 3'b011,
		SRC_ZA = 3'b100,
		SRC_DA = 3'b101,
		SRC_DQ = 3'b110,
		SRC_DZ = 3'b111
	} fsad_src_type;

	typedef enum logic [2:0] {
		FN_ADD = 3'b000,
		FN_SUBR = 3'b001,
		FN_SUBS = 3'b010,
		FN_OR = 3'b011,
		FN_AND = 3'b100,
		FN_MASK = 3'b101,
		FN_XOR = 3'b110,
		FN_XNOR = 3'b111
	} fsad_func_type;

	typedef enum logic [2:0] {
		DST_QREG = 3'b000,
		DST_NOP = 3'b001,
		DST_RAMA = 3'b010,
		DST_RAMF = 3'b011,
		DST_RAMQD = 3'b100,
		DST_RAMD = 3'b101,
		DST_RAMQU = 3'b110,
		DST_RAMU = 3'b111
	} fsad_dest_type;

	localparam logic [3:0] ZERO_WORD = 4'h0;

endpackage

// *** rtl/fsad_alu.sv ***
// Eight-function ALU with lookahead and status terms.
`timescale 1ns/1ps
module fsad_alu (
	input wire logic [3:0] r,
	input wire logic [3:0] s,
	input wire fsad_pkg::fsad_func_type func,
	input wire logic carry_in,
	output logic [3:0] f,
	output logic carry_out,
	output logic propagate_n,
	output logic generate_n,
	output logic overflow
);

	logic [3:0] rr;
	logic [3:0] ss;
	logic [3:0] p;
	logic [3:0] g;
	logic pall;
	logic glook;
	logic [4:0] sum;
	logic [3:0] low;
	logic t2;
	logic t3;

	// ----------------------------------------
	// Operand conditioning and carry terms
	// ----------------------------------------
	always_comb begin
		rr = r;
		ss = s;
		if (func == fsad_pkg::FN_SUBR || func == fsad_pkg::FN_MASK || func == fsad_pkg::FN_XOR) begin
			rr = ~r;
		end
		if (func == fsad_pkg::FN_SUBS) begin
			ss = ~s;
		end
		p = rr | ss;
		g = rr & ss;
		pall = &p;
		glook = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]);
		sum = {1'b0, rr} + {1'b0, ss} + {4'h0, carry_in};
		low = {1'b0, rr[2:0]} + {1'b0, ss[2:0]} + {3'h0, carry_in};
		t2 = ~p[2] | (~g[2] & ~p[1]) | (~g[2] & ~g[1] & ~p[0]) | (~g[2] & ~g[1] & ~g[0] & carry_in);
		t3 = ~p[3] | (~g[3] & ~p[2]) | (~g[3] & ~g[2] & ~p[1]) | (~g[3] & ~g[2] & ~g[1] & ~p[0])
			| (~g[3] & ~g[2] & ~g[1] & ~g[0] & carry_in);
		case (func)
			fsad_pkg::FN_ADD, fsad_pkg::FN_SUBR, fsad_pkg::FN_SUBS: begin
				f = sum[3:0];
				carry_out = sum[4];
				propagate_n = ~pall;
				generate_n = ~glook;
				overflow = low[3] ^ sum[4];
			end
			fsad_pkg::FN_OR: begin
				f = r | s;
				carry_out = ~pall | carry_in;
				propagate_n = 1'b0;
				generate_n = pall;
				overflow = ~pall | carry_in;
			end
			fsad_pkg::FN_AND, fsad_pkg::FN_MASK: begin
				f = rr & s;
				carry_out = (|g) | carry_in;
				propagate_n = 1'b0;
				generate_n = ~(|g);
				overflow = (|g) | carry_in;
			end
			default: begin
				f = (func == fsad_pkg::FN_XOR) ? (r ^ s) : ~(r ^ s);
				carry_out = ~glook | (pall & (g[0] | ~carry_in));
				propagate_n = |g;
				generate_n = glook;
				overflow = t2 ^ t3;
			end
		endcase
	end

endmodule

// *** rtl/fsad_regfile.sv ***
// Sixteen-word by four-bit register file with two read ports.
`timescale 1ns/1ps
module fsad_regfile (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] a_address,
	input wire logic [3:0] b_address,
	input wire logic write_en,
	input wire logic [3:0] write_data,
	output logic [3:0] a_data,
	output logic [3:0] b_data
);

	logic [3:0] mem_q [fsad_pkg::WORDS];
	logic [3:0] mem_d [fsad_pkg::WORDS];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Words are never cleared; software must write before reading.
	genvar gi;
	generate
		for (gi = 0; gi < fsad_pkg::WORDS; gi++) begin : g_word
			always_comb begin
				mem_d[gi] = mem_q[gi];
				if (write_en && b_address == 4'(gi)) begin
					mem_d[gi] = write_data;
				end
			end
			always_ff @(posedge clk) begin
				mem_q[gi] <= mem_d[gi];
			end
		end
	endgenerate

	// Reads see the word before this cycle's write, as the port latches intend.
	always_comb begin
		a_data = mem_q[a_address];
		b_data = mem_q[b_address];
	end

	chk_rf_write: assert property (@(posedge clk) disable iff (rst)
		write_en |=> mem_q[$past(b_address)] == $past(write_data))
		else $error("register file word not written");

	chk_rf_same_port: assert property (@(posedge clk) disable iff (rst)
		(a_address == b_address) |-> (a_data == b_data))
		else $error("equal addresses gave different data");

endmodule

// *** rtl/fsad_top.sv ***
// Four-bit cascadable datapath slice: operand select, ALU, shifters, Q and output mux.
`timescale 1ns/1ps
// How it works
// - Source code picks R,S: AQ, AB, 0Q, 0B, 0A, DA, DQ, D0.
// - Function code picks add, two subtracts, OR, AND, mask, XOR, XNOR.
// - Arithmetic adds carry in; subtraction adds ones complement plus carry.
// - Logic functions ignore carry in for the result.
// - Carry out of the ALU is active high, as is carry in.
// - Active-low group propagate and generate feed an outside lookahead unit.
// - Propagate and generate follow bitwise OR/AND terms, complemented subtrahend.
// - Sign pin shows result MSB regardless of output enable.
// - Zero detect is open drain, released high when result is zero.
// - Arithmetic overflow is carry into MSB differing from carry out.
// - Dest 0 loads Q, 1 nothing, 2/3 write B; 2 outputs A.
// - Dest 4/5 write result shifted down; 4 also shifts Q down.
// - Dest 6/7 write result shifted up; 6 also shifts Q up.
// - Shift pins drive only when emitting; otherwise they are inputs.
// - Q mux takes the result unshifted, Q shifted up or down, else Q unchanged.
// - Active-low output enable drives or releases the data outputs.
// - Q loads on the rising clock edge when selected.
// - Read ports hold pre-write data so reads never race writes.
// - Enabled writes store the shifter output at the B address.
// - Sixteen four-bit words, two independent read addresses.
// - Direct data, carry in and the shift pin inputs are the only ways external data enters.
module fsad_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] source_select_code,
	input wire logic [2:0] function_select_code,
	input wire logic [2:0] destination_select_code,
	input wire logic [3:0] a_address,
	input wire logic [3:0] b_address,
	input wire logic [3:0] direct_data,
	input wire logic carry_input,
	input wire logic output_enable_n,
	output logic [3:0] y_out,
	output logic y_oe,
	output logic carry_output,
	output logic propagate_n,
	output logic generate_n,
	output logic result_sign_bit,
	output logic zero_detect_out,
	output logic zero_detect_oe,
	output logic twos_complement_overflow,
	input wire logic regfile_lsb_shift_pin_in,
	output logic regfile_lsb_shift_pin_out,
	output logic regfile_lsb_shift_pin_oe,
	input wire logic regfile_msb_shift_pin_in,
	output logic regfile_msb_shift_pin_out,
	output logic regfile_msb_shift_pin_oe,
	input wire logic work_reg_lsb_shift_pin_in,
	output logic work_reg_lsb_shift_pin_out,
	output logic work_reg_lsb_shift_pin_oe,
	input wire logic work_reg_msb_shift_pin_in,
	output logic work_reg_msb_shift_pin_out,
	output logic work_reg_msb_shift_pin_oe
);

	fsad_pkg::fsad_src_type src;
	fsad_pkg::fsad_func_type func;
	fsad_pkg::fsad_dest_type dest;
	logic [3:0] a_data;
	logic [3:0] b_data;
	logic [3:0] r;
	logic [3:0] s;
	logic [3:0] f;
	logic [3:0] q_q;
	logic [3:0] q_d;
	logic ram_we;
	logic [3:0] ram_wdata;

	assign src = fsad_pkg::fsad_src_type'(source_select_code);
	assign func = fsad_pkg::fsad_func_type'(function_select_code);
	assign dest = fsad_pkg::fsad_dest_type'(destination_select_code);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	fsad_regfile u_regfile (
		.clk(clk),
		.rst(rst),
		.a_address(a_address),
		.b_address(b_address),
		.write_en(ram_we),
		.write_data(ram_wdata),
		.a_data(a_data),
		.b_data(b_data)
	);

	// ----------------------------------------
	// Operand select
	// ----------------------------------------
	// The outputs stay combinational so that cascaded slices see each other's
	// shift and carry terms within the same microcycle.
	always_comb begin
		case (src)
			fsad_pkg::SRC_AQ: begin
				r = a_data;
				s = q_q;
			end
			fsad_pkg::SRC_AB: begin
				r = a_data;
				s = b_data;
			end
			fsad_pkg::SRC_ZQ: begin
				r = fsad_pkg::ZERO_WORD;
				s = q_q;
			end
			fsad_pkg::SRC_ZB: begin
				r = fsad_pkg::ZERO_WORD;
				s = b_data;
			end
			fsad_pkg::SRC_ZA: begin
				r = fsad_pkg::ZERO_WORD;
				s = a_data;
			end
			fsad_pkg::SRC_DA: begin
				r = direct_data;
				s = a_data;
			end
			fsad_pkg::SRC_DQ: begin
				r = direct_data;
				s = q_q;
			end
			default: begin
				r = direct_data;
				s = fsad_pkg::ZERO_WORD;
			end
		endcase
	end

	// ----------------------------------------
	// ALU
	// ----------------------------------------
	fsad_alu u_alu (
		.r(r),
		.s(s),
		.func(func),
		.carry_in(carry_input),
		.f(f),
		.carry_out(carry_output),
		.propagate_n(propagate_n),
		.generate_n(generate_n),
		.overflow(twos_complement_overflow)
	);

	// ----------------------------------------
	// Status and data outputs
	// ----------------------------------------
	always_comb begin
		result_sign_bit = f[3];
		zero_detect_out = 1'b0;
		zero_detect_oe = (f != fsad_pkg::ZERO_WORD);
		y_out = (dest == fsad_pkg::DST_RAMA) ? a_data : f;
		y_oe = ~output_enable_n;
	end

	// ----------------------------------------
	// RAM shifter and shift pins
	// ----------------------------------------
	always_comb begin
		ram_we = 1'b0;
		ram_wdata = f;
		regfile_lsb_shift_pin_out = f[0];
		regfile_msb_shift_pin_out = f[3];
		work_reg_lsb_shift_pin_out = q_q[0];
		work_reg_msb_shift_pin_out = q_q[3];
		regfile_lsb_shift_pin_oe = 1'b0;
		regfile_msb_shift_pin_oe = 1'b0;
		work_reg_lsb_shift_pin_oe = 1'b0;
		work_reg_msb_shift_pin_oe = 1'b0;
		case (dest)
			fsad_pkg::DST_RAMA, fsad_pkg::DST_RAMF: begin
				ram_we = 1'b1;
			end
			fsad_pkg::DST_RAMQD, fsad_pkg::DST_RAMD: begin
				ram_we = 1'b1;
				ram_wdata = {regfile_msb_shift_pin_in, f[3:1]};
				regfile_lsb_shift_pin_oe = 1'b1;
				work_reg_lsb_shift_pin_oe = 1'b1;
			end
			fsad_pkg::DST_RAMQU, fsad_pkg::DST_RAMU: begin
				ram_we = 1'b1;
				ram_wdata = {f[2:0], regfile_lsb_shift_pin_in};
				regfile_msb_shift_pin_oe = 1'b1;
				work_reg_msb_shift_pin_oe = 1'b1;
			end
			default: begin
				ram_we = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Q register
	// ----------------------------------------
	always_comb begin
		case (dest)
			fsad_pkg::DST_QREG: q_d = f;
			fsad_pkg::DST_RAMQD: q_d = {work_reg_msb_shift_pin_in, q_q[3:1]};
			fsad_pkg::DST_RAMQU: q_d = {q_q[2:0], work_reg_lsb_shift_pin_in};
			default: q_d = q_q;
		endcase
	end

	// No reset here: Q starts undefined, like the register file.
	always_ff @(posedge clk) begin
		q_q <= q_d;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_q_load_result: assert property (@(posedge clk) disable iff (rst)
		(dest == fsad_pkg::DST_QREG) |=> (q_q == $past(f)))
		else $error("Q did not load the ALU result");

	chk_q_shift_down: assert property (@(posedge clk) disable iff (rst)
		(dest == fsad_pkg::DST_RAMQD) |=> (q_q == {$past(work_reg_msb_shift_pin_in), $past(q_q[3:1])}))
		else $error("Q down shift wrong");

	chk_q_shift_up: assert property (@(posedge clk) disable iff (rst)
		(dest == fsad_pkg::DST_RAMQU) |=> (q_q == {$past(q_q[2:0]), $past(work_reg_lsb_shift_pin_in)}))
		else $error("Q up shift wrong");

	chk_q_holds: assert property (@(posedge clk) disable iff (rst)
		(dest inside {fsad_pkg::DST_NOP, fsad_pkg::DST_RAMA, fsad_pkg::DST_RAMF, fsad_pkg::DST_RAMD,
		fsad_pkg::DST_RAMU}) |=> $stable(q_q))
		else $error("Q changed without a load");

	chk_pins_idle: assert property (@(posedge clk) disable iff (rst)
		(dest[2] == 1'b0) |-> !(regfile_lsb_shift_pin_oe || regfile_msb_shift_pin_oe
		|| work_reg_lsb_shift_pin_oe || work_reg_msb_shift_pin_oe))
		else $error("shift pin driven without a shift");

	chk_pins_down: assert property (@(posedge clk) disable iff (rst)
		(dest == fsad_pkg::DST_RAMD) |-> regfile_lsb_shift_pin_oe && !regfile_msb_shift_pin_oe
		&& regfile_lsb_shift_pin_out == f[0] && ram_wdata[3] == regfile_msb_shift_pin_in)
		else $error("down shift pins wrong");

	chk_y_port_a: assert property (@(posedge clk) disable iff (rst)
		(dest == fsad_pkg::DST_RAMA) |-> (y_out == a_data) && ram_we)
		else $error("A port not on data outputs");

	chk_zero_flag: assert property (@(posedge clk) disable iff (rst)
		(zero_detect_oe == 1'b0) |-> (f == fsad_pkg::ZERO_WORD) && (result_sign_bit == 1'b0))
		else $error("zero detect released on nonzero result");

	chk_sub_true: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_SUBS && carry_input) |-> (f == 4'(r - s)))
		else $error("R minus S with carry not exact");

	chk_or_ignore_cin: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_OR) |-> (f == (r | s)))
		else $error("OR result depends on carry");

	chk_add_overflow: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_ADD && r[3] == s[3]) |-> (twos_complement_overflow == (f[3] != r[3])))
		else $error("overflow flag wrong for add");

	chk_y_enable: assert property (@(posedge clk) disable iff (rst)
		output_enable_n |-> !y_oe)
		else $error("data outputs driven while disabled");

	chk_src_zero_r: assert property (@(posedge clk) disable iff (rst)
		(src inside {fsad_pkg::SRC_ZQ, fsad_pkg::SRC_ZB, fsad_pkg::SRC_ZA}) |-> (r == fsad_pkg::ZERO_WORD))
		else $error("zero operand not selected");

	chk_src_direct: assert property (@(posedge clk) disable iff (rst)
		(src inside {fsad_pkg::SRC_DA, fsad_pkg::SRC_DQ, fsad_pkg::SRC_DZ}) |-> (r == direct_data))
		else $error("direct data not on R");

	chk_src_q_pick: assert property (@(posedge clk) disable iff (rst)
		(src inside {fsad_pkg::SRC_AQ, fsad_pkg::SRC_ZQ, fsad_pkg::SRC_DQ}) |-> (s == q_q))
		else $error("Q not on S");

	chk_sign_free: assert property (@(posedge clk) disable iff (rst)
		output_enable_n |-> (result_sign_bit == f[3]))
		else $error("sign pin lost while outputs disabled");

	chk_pins_up: assert property (@(posedge clk) disable iff (rst)
		(dest == fsad_pkg::DST_RAMU) |-> regfile_msb_shift_pin_oe && !regfile_lsb_shift_pin_oe
		&& work_reg_msb_shift_pin_oe && regfile_msb_shift_pin_out == f[3]
		&& work_reg_msb_shift_pin_out == q_q[3] && ram_wdata[0] == regfile_lsb_shift_pin_in)
		else $error("up shift pins wrong");

	chk_and_ignore_cin: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_AND) |-> (f == (r & s)))
		else $error("AND result depends on carry");

	chk_add_carry: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_ADD) |-> ({carry_output, f} == {1'b0, r} + {1'b0, s} + {4'h0, carry_input}))
		else $error("sum or carry out wrong for add");

	chk_add_propagate: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_ADD) |-> (propagate_n == !(&(r | s))))
		else $error("group propagate wrong for add");

	chk_or_carry: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_OR) |-> (carry_output == (!(&(r | s)) || carry_input)))
		else $error("carry out wrong for OR");

	chk_xnor_propagate: assert property (@(posedge clk) disable iff (rst)
		(func == fsad_pkg::FN_XNOR) |-> (propagate_n == (|(r & s))))
		else $error("group propagate wrong for XNOR");

	chk_ram_no_write: assert property (@(posedge clk) disable iff (rst)
		(dest inside {fsad_pkg::DST_QREG, fsad_pkg::DST_NOP}) |-> !ram_we)
		else $error("register file written on a no-write code");

endmodule

// *** bench/fsad_neighbor.sv ***
// Model of the adjacent cascaded slices that meet this slice at its shift pins.
`timescale 1ns/1ps
module fsad_neighbor (
	input wire logic clk,
	input wire logic [2:0] destination_select_code,
	input wire logic [1:0] up_bits,
	input wire logic [1:0] down_bits,
	input wire logic regfile_lsb_shift_pin_out,
	input wire logic regfile_lsb_shift_pin_oe,
	input wire logic regfile_msb_shift_pin_out,
	input wire logic regfile_msb_shift_pin_oe,
	input wire logic work_reg_lsb_shift_pin_out,
	input wire logic work_reg_lsb_shift_pin_oe,
	input wire logic work_reg_msb_shift_pin_out,
	input wire logic work_reg_msb_shift_pin_oe,
	output logic regfile_lsb_shift_pin_in,
	output logic regfile_msb_shift_pin_in,
	output logic work_reg_lsb_shift_pin_in,
	output logic work_reg_msb_shift_pin_in
);
	logic idle_q = 1'b0;
	logic down;
	logic up;
	// A pin that nobody drives shows a changing level, so a stale value can never pass.
	always @(posedge clk) begin
		idle_q <= ~idle_q;
	end
	assign down = destination_select_code[2] & ~destination_select_code[1];
	assign up = &destination_select_code[2:1];
	// The upper slice feeds the high pins on a down shift, the lower slice the low pins on an up shift.
	always_comb begin
		regfile_msb_shift_pin_in = regfile_msb_shift_pin_oe ? regfile_msb_shift_pin_out : (down ? down_bits[1] : idle_q);
		work_reg_msb_shift_pin_in = work_reg_msb_shift_pin_oe ? work_reg_msb_shift_pin_out : (down ? down_bits[0] : idle_q);
		regfile_lsb_shift_pin_in = regfile_lsb_shift_pin_oe ? regfile_lsb_shift_pin_out : (up ? up_bits[1] : ~idle_q);
		work_reg_lsb_shift_pin_in = work_reg_lsb_shift_pin_oe ? work_reg_lsb_shift_pin_out : (up ? up_bits[0] : ~idle_q);
	end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the four-bit slice datapath.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [3:0] y;
		logic y_oe;
		logic arith;
		logic [3:0] flags;
		logic [1:0] stat;
		logic [3:0] pin_oe;
		logic [3:0] pin_out;
	} fsad_exp_type;
	logic clk, rst, carry_input, output_enable_n, y_oe, carry_output, propagate_n, generate_n;
	logic [2:0] source_select_code, function_select_code, destination_select_code;
	logic [3:0] a_address, b_address, direct_data, y_out;
	logic result_sign_bit, zero_detect_out, zero_detect_oe, twos_complement_overflow;
	logic regfile_lsb_shift_pin_in, regfile_lsb_shift_pin_out, regfile_lsb_shift_pin_oe;
	logic regfile_msb_shift_pin_in, regfile_msb_shift_pin_out, regfile_msb_shift_pin_oe;
	logic work_reg_lsb_shift_pin_in, work_reg_lsb_shift_pin_out, work_reg_lsb_shift_pin_oe;
	logic work_reg_msb_shift_pin_in, work_reg_msb_shift_pin_out, work_reg_msb_shift_pin_oe;
	logic [1:0] up_bits, down_bits;
	logic [3:0] ram_m [16];
	logic [3:0] q_m;
	fsad_exp_type exp_q [$];
	fsad_exp_type e_m;
	int mismatches = 0;
	int samples_checked = 0;

	fsad_top i_dut (.clk, .rst, .source_select_code, .function_select_code, .destination_select_code,
		.a_address, .b_address, .direct_data, .carry_input, .output_enable_n, .y_out, .y_oe,
		.carry_output, .propagate_n, .generate_n, .result_sign_bit, .zero_detect_out, .zero_detect_oe,
		.twos_complement_overflow, .regfile_lsb_shift_pin_in, .regfile_lsb_shift_pin_out,
		.regfile_lsb_shift_pin_oe, .regfile_msb_shift_pin_in, .regfile_msb_shift_pin_out,
		.regfile_msb_shift_pin_oe, .work_reg_lsb_shift_pin_in, .work_reg_lsb_shift_pin_out,
		.work_reg_lsb_shift_pin_oe, .work_reg_msb_shift_pin_in, .work_reg_msb_shift_pin_out,
		.work_reg_msb_shift_pin_oe);
	fsad_neighbor i_nb (.clk, .destination_select_code, .up_bits, .down_bits,
		.regfile_lsb_shift_pin_out, .regfile_lsb_shift_pin_oe, .regfile_msb_shift_pin_out,
		.regfile_msb_shift_pin_oe, .work_reg_lsb_shift_pin_out, .work_reg_lsb_shift_pin_oe,
		.work_reg_msb_shift_pin_out, .work_reg_msb_shift_pin_oe, .regfile_lsb_shift_pin_in,
		.regfile_msb_shift_pin_in, .work_reg_lsb_shift_pin_in, .work_reg_msb_shift_pin_in);

	// ----------------------------------------
	// Clock, checking and closing
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Outputs are combinational, so the falling edge sees them settled for the current microinstruction.
	always @(negedge clk) begin
		if (exp_q.size() > 0) begin
			e_m = exp_q.pop_front();
			check({3'h0, y_oe}, {3'h0, e_m.y_oe});
			if (e_m.y_oe) check(y_out, e_m.y);
			check({3'h0, result_sign_bit}, {3'h0, e_m.stat[1]});
			check({3'h0, zero_detect_oe ? zero_detect_out : 1'b1}, {3'h0, e_m.stat[0]});
			if (e_m.arith) check({carry_output, propagate_n, generate_n,
				twos_complement_overflow}, e_m.flags);
			check({regfile_lsb_shift_pin_oe, regfile_msb_shift_pin_oe, work_reg_lsb_shift_pin_oe,
				work_reg_msb_shift_pin_oe}, e_m.pin_oe);
			check({regfile_lsb_shift_pin_out, regfile_msb_shift_pin_out,
				work_reg_lsb_shift_pin_out, work_reg_msb_shift_pin_out} & e_m.pin_oe, e_m.pin_out & e_m.pin_oe);
		end
	end

	// ----------------------------------------
	// Driver with reference model
	// ----------------------------------------
	task automatic step(input logic [2:0] s_c, f_c, d_c, input logic [3:0] a_v, b_v, d_v, input logic c_v, o_v);
		logic [3:0] r, s, f, rr, ss, p, g;
		logic [4:0] sum, low;
		fsad_exp_type e;
		source_select_code = s_c;
		function_select_code = f_c;
		destination_select_code = d_c;
		a_address = a_v;
		b_address = b_v;
		direct_data = d_v;
		carry_input = c_v;
		output_enable_n = o_v;
		up_bits = 2'($urandom);
		down_bits = 2'($urandom);
		r = (s_c < 3'd2) ? ram_m[a_v] : ((s_c < 3'd5) ? 4'h0 : d_v);
		case (s_c)
			3'd1, 3'd3: s = ram_m[b_v];
			3'd4, 3'd5: s = ram_m[a_v];
			3'd7: s = 4'h0;
			default: s = q_m;
		endcase
		rr = (f_c == 3'd1) ? ~r : r;
		ss = (f_c == 3'd2) ? ~s : s;
		sum = {1'b0, rr} + {1'b0, ss} + {4'h0, c_v};
		low = {2'h0, rr[2:0]} + {2'h0, ss[2:0]} + {4'h0, c_v};
		case (f_c)
			3'd3: f = r | s;
			3'd4: f = r & s;
			3'd5: f = ~r & s;
			3'd6: f = r ^ s;
			3'd7: f = ~(r ^ s);
			default: f = sum[3:0];
		endcase
		p = rr | ss;
		g = rr & ss;
		e.flags = {sum[4], ~&p, ~(g[3] | p[3] & g[2] | &p[3:2] & g[1] | &p[3:1] & g[0]), low[3] ^ sum[4]};
		e.arith = (f_c < 3'd3);
		e.y = (d_c == 3'd2) ? ram_m[a_v] : f;
		e.y_oe = ~o_v;
		e.stat = {f[3], f == 4'h0};
		e.pin_oe = {d_c[2] & ~d_c[1], &d_c[2:1], d_c[2] & ~d_c[1], &d_c[2:1]};
		e.pin_out = {f[0], f[3], q_m[0], q_m[3]};
		exp_q.push_back(e);
		@(posedge clk);
		if (d_c == 3'd0) q_m = f;
		if (d_c == 3'd4) q_m = {down_bits[0], q_m[3:1]};
		if (d_c == 3'd6) q_m = {q_m[2:0], up_bits[0]};
		case (d_c)
			3'd2, 3'd3: ram_m[b_v] = f;
			3'd4, 3'd5: ram_m[b_v] = {down_bits[1], f[3:1]};
			3'd6, 3'd7: ram_m[b_v] = {f[2:0], up_bits[1]};
			default: ;
		endcase
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		{source_select_code, function_select_code, destination_select_code} = 9'h1f9;
		{a_address, b_address, direct_data, carry_input, output_enable_n} = 14'h0000;
		{up_bits, down_bits} = 4'h0;
		void'($urandom(32'h0000_5ade));
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		// Nothing is known after power-up: Q is loaded first, and the A address never meets the word
		// being written, so no check ever reads a word that is still unknown.
		step(3'd7, 3'd3, 3'd0, 4'h1, 4'h0, 4'($urandom), 1'b1, 1'b0);
		for (int i = 0; i < 16; i++) step(3'd7, 3'd3, 3'd3, 4'(i + 1), 4'(i), 4'($urandom), 1'b0, 1'b0);
		$display("test load_all done");
		for (int i = 0; i < 128; i++) step(3'(i), 3'(i >> 3), 3'd1, 4'($urandom), 4'($urandom),
			4'($urandom), 1'(i >> 6), 1'($urandom));
		$display("test operand_function done");
		for (int i = 0; i < 600; i++) step(3'($urandom), 3'($urandom), 3'(i), 4'($urandom),
			4'($urandom), 4'($urandom), 1'($urandom), 1'($urandom));
		$display("test destination_shift done");
		for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk);
		if (exp_q.size() > 0) mismatches++;
		end_sim();
	end
endmodule
